// ---- inc/fesr_pkg.sv ----
// Constants for the erase and suspend/resume sequencer of a serial flash.
// Assumes a 10 MHz core clock and an AXI4-Lite master for the registers.
package fesr_pkg;
   localparam int CLK_PERIOD_NS = 100;
   localparam int RESUME_MAX_NS = 200;
   localparam int RESUME_MAX_CYC = RESUME_MAX_NS / CLK_PERIOD_NS;
   // Opcodes
   localparam logic [7:0] OP_WRSR = 8'h01;
   localparam logic [7:0] OP_PP = 8'h02;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_PP4 = 8'h12;
   localparam logic [7:0] OP_SE = 8'h20;
   localparam logic [7:0] OP_SE4 = 8'h21;
   localparam logic [7:0] OP_QPP = 8'h32;
   localparam logic [7:0] OP_QPP4 = 8'h34;
   localparam logic [7:0] OP_PSR = 8'h42;
   localparam logic [7:0] OP_ESR = 8'h44;
   localparam logic [7:0] OP_BE32 = 8'h52;
   localparam logic [7:0] OP_CE2 = 8'h60;
   localparam logic [7:0] OP_SUSP = 8'h75;
   localparam logic [7:0] OP_RESM = 8'h7a;
   localparam logic [7:0] OP_CE = 8'hc7;
   localparam logic [7:0] OP_BE64 = 8'hd8;
   localparam logic [7:0] OP_BE64_4 = 8'hdc;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_PROT = 8'h04;
   localparam logic [7:0] REG_LOCK = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   // Field positions
   localparam int CTRL_ADDR4 = 0;
   localparam int ST_BUSY = 0;
   localparam int ST_WLATCH = 1;
   localparam int ST_SUSP = 2;
   localparam int ST_SUSP_ERASE = 3;
   localparam int PROT_W = 6;
   localparam logic [5:0] PROT_RESET = 6'h00;
   localparam logic [31:0] LOCK_RESET = 32'h0000_0000;
   // Array geometry, 64 KB blocks in a 32 MB array
   localparam logic [9:0] NUM_BLOCKS = 10'h200;
   localparam logic [3:0] BP_ALL = 4'ha;
   localparam logic [31:0] MASK_4K = 32'hffff_f000;
   localparam logic [31:0] MASK_32K = 32'hffff_8000;
   localparam logic [31:0] MASK_64K = 32'hffff_0000;
   localparam logic [31:0] MASK_PAGE = 32'hffff_ff00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Operation kind code on the array port: erase sizes, page program, status write
   typedef enum logic [2:0] {K_SE, K_BE32, K_BE64, K_CE, K_PP, K_WRSR}
      fesr_kind_t;
endpackage : fesr_pkg

// ---- logic/fesr_ctrl.sv ----
// Erase, suspend and resume sequencer of a serial flash, with SPI command
// input and an AXI4-Lite register slave. Assumes SPI pins are asynchronous
// to CLK_IN and the array acts on the erase and program strobes it emits.
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.

module fesr_ctrl #(
   parameter int SE_TIME_US = 50,
   parameter int BE32_TIME_US = 120,
   parameter int BLOCK64_ERASE_TIME_US = 150,
   parameter int CE_TIME_US = 1000,
   parameter int PP_TIME_US = 40,
   parameter int WRSR_TIME_US = 10,
   parameter int SUS_LAT_US = 20
) (
   input wire logic CLK_IN, // Core clock
   input wire logic RST_IN, // Async reset, active high
   input wire logic CE_IN, // Clock enable
   input wire logic SCK_IN, // Serial clock pin
   input wire logic CS_N_IN, // Select pin, active low
   input wire logic DI_IN, // Serial data in pin
   input wire logic [7:0] S_AXI_AWADDR_IN, // Write address
   input wire logic S_AXI_AWVALID_IN, // Write address valid
   output logic S_AXI_AWREADY_OUT, // Write address ready
   input wire logic [31:0] S_AXI_WDATA_IN, // Write data
   input wire logic [3:0] S_AXI_WSTRB_IN, // Write strobes
   input wire logic S_AXI_WVALID_IN, // Write data valid
   output logic S_AXI_WREADY_OUT, // Write data ready
   output logic [1:0] S_AXI_BRESP_OUT, // Write response
   output logic S_AXI_BVALID_OUT, // Write response valid
   input wire logic S_AXI_BREADY_IN, // Write response ready
   input wire logic [7:0] S_AXI_ARADDR_IN, // Read address
   input wire logic S_AXI_ARVALID_IN, // Read address valid
   output logic S_AXI_ARREADY_OUT, // Read address ready
   output logic [31:0] S_AXI_RDATA_OUT, // Read data
   output logic [1:0] S_AXI_RRESP_OUT, // Read response
   output logic S_AXI_RVALID_OUT, // Read data valid
   input wire logic S_AXI_RREADY_IN, // Read data ready
   output logic ERASE_STB_OUT, // One-cycle erase-to-FFh strobe
   output logic PROG_STB_OUT, // One-cycle program done strobe
   output logic [31:0] ARRAY_ADDR_OUT, // Aligned base of erase or page
   output logic [2:0] ARRAY_KIND_OUT, // Kind of the strobed operation
   output logic BUSY_OUT, // Busy flag
   output logic SUSPEND_OUT // Suspend flag
);
   localparam int US_CYC = 1000 / fesr_pkg::CLK_PERIOD_NS;
   localparam int SUS_LAT_CYC = SUS_LAT_US * US_CYC;
   localparam int SUS_CHK = SUS_LAT_CYC + 1;
   if (SE_TIME_US < 1 || BE32_TIME_US < 1 || BLOCK64_ERASE_TIME_US < 1 ||
       CE_TIME_US < 1 || PP_TIME_US < 1 || WRSR_TIME_US < 1 ||
       SUS_LAT_US < 1)
   begin : g_time_chk
      $error("fesr_ctrl: all times must be at least 1 us");
   end
   typedef enum logic [1:0] {S_IDLE, S_RUN, S_SUSP} fesr_state_t;

   function automatic logic [31:0] kind_cyc(input fesr_pkg::fesr_kind_t k);
      int t;
      t = WRSR_TIME_US;
      unique case (k)
         fesr_pkg::K_SE: t = SE_TIME_US;
         fesr_pkg::K_BE32: t = BE32_TIME_US;
         fesr_pkg::K_BE64: t = BLOCK64_ERASE_TIME_US;
         fesr_pkg::K_CE: t = CE_TIME_US;
         fesr_pkg::K_PP: t = PP_TIME_US;
         default: t = WRSR_TIME_US;
      endcase
      return 32'(t * US_CYC);
   endfunction : kind_cyc

   // Block lies in the range-bit window, or outside it when p[5] is set, or in the lock mask
   function automatic logic blk_prot(input logic [8:0] blk,
      input logic [5:0] p, input logic [31:0] lk);
      logic [9:0] n;
      logic in_rng;
      n = (p[3:0] == 4'h0) ? 10'h000 : (p[3:0] >= fesr_pkg::BP_ALL) ?
         fesr_pkg::NUM_BLOCKS : 10'h001 << (p[3:0] - 4'h1);
      in_rng = p[4] ? ({1'b0, blk} < n) :
         ({1'b0, blk} >= fesr_pkg::NUM_BLOCKS - n);
      return (in_rng ^ p[5]) | ((blk < 9'h020) & lk[blk[4:0]]);
   endfunction : blk_prot

   // Pin synchronisers
   logic sck_s1_q, sck_s2_q, sck_d_q, cs_s1_q, cs_s2_q, cs_d_q;
   logic di_s1_q, di_s2_q;
   always_ff @(posedge CLK_IN or posedge RST_IN)
      if (RST_IN)
      begin
         {sck_s1_q, sck_s2_q, sck_d_q} <= 3'h0;
         {cs_s1_q, cs_s2_q, cs_d_q} <= 3'h7;
         {di_s1_q, di_s2_q} <= 2'h0;
      end
      else if (CE_IN)
      begin
         {sck_s1_q, sck_s2_q, sck_d_q} <= {SCK_IN, sck_s1_q, sck_s2_q};
         {cs_s1_q, cs_s2_q, cs_d_q} <= {CS_N_IN, cs_s1_q, cs_s2_q};
         {di_s1_q, di_s2_q} <= {DI_IN, di_s1_q};
      end
   wire sck_rise = sck_s2_q & ~sck_d_q;
   wire cs_rise = cs_s2_q & ~cs_d_q;
   wire bit_in = sck_rise & ~cs_s2_q;

   // Command shifter
   logic [31:0] sh_q, cap_addr_q;
   logic [2:0] bitph_q;
   logic [3:0] bytes_q;
   logic [7:0] op_q, dat_q;
   logic addr4_q;
   wire [31:0] sh_d = {sh_q[30:0], di_s2_q};
   wire byte_end = bit_in & (bitph_q == 3'h7);
   wire op_a32 = (op_q == fesr_pkg::OP_SE4) | (op_q == fesr_pkg::OP_BE64_4) |
      (op_q == fesr_pkg::OP_PP4) | (op_q == fesr_pkg::OP_QPP4);
   wire op_amode = (op_q == fesr_pkg::OP_SE) | (op_q == fesr_pkg::OP_BE32) |
      (op_q == fesr_pkg::OP_BE64) | (op_q == fesr_pkg::OP_PP) |
      (op_q == fesr_pkg::OP_QPP) | (op_q == fesr_pkg::OP_PSR);
   wire [3:0] abytes = (op_a32 | (op_amode & addr4_q)) ? 4'h4 :
      op_amode ? 4'h3 : 4'h0;
   always_ff @(posedge CLK_IN or posedge RST_IN)
      if (RST_IN)
      begin
         sh_q <= 32'h0;
         bitph_q <= 3'h0;
         bytes_q <= 4'h0;
         op_q <= 8'h00;
         dat_q <= 8'h00;
         cap_addr_q <= 32'h0;
      end
      else if (CE_IN)
      begin
         if (cs_s2_q)
         begin
            bitph_q <= 3'h0;
            if (cs_d_q)
               bytes_q <= 4'h0;
         end
         else if (bit_in)
         begin
            sh_q <= sh_d;
            bitph_q <= bitph_q + 3'h1;
            if (byte_end && bytes_q != 4'hf)
               bytes_q <= bytes_q + 4'h1;
            if (byte_end && bytes_q == 4'h0)
               op_q <= sh_d[7:0];
            if (byte_end && bytes_q != 4'h0 && bytes_q == abytes)
               cap_addr_q <= (abytes == 4'h4) ? sh_d : {8'h00, sh_d[23:0]};
            if (byte_end && bytes_q != 4'h0 && bytes_q == abytes + 4'h1)
               dat_q <= sh_d[7:0];
         end
      end

   // Decode at select rise
   logic [5:0] prot_q;
   logic [31:0] lock_q, cnt_q, sv_cnt_q, cur_addr_q, sv_addr_q;
   logic [7:0] wrsr_val_q;
   logic wl_q, sus_q;
   fesr_state_t st_q;
   fesr_pkg::fesr_kind_t kind_q, sv_kind_q, new_kind;
   wire bound = (bitph_q == 3'h0);
   wire len1 = bound & (bytes_q == 4'h1);
   wire is_se = (op_q == fesr_pkg::OP_SE) | (op_q == fesr_pkg::OP_SE4);
   wire is_b64 = (op_q == fesr_pkg::OP_BE64) | (op_q == fesr_pkg::OP_BE64_4);
   wire is_b32 = op_q == fesr_pkg::OP_BE32;
   wire is_ce = (op_q == fesr_pkg::OP_CE) | (op_q == fesr_pkg::OP_CE2);
   wire is_erase = is_se | is_b32 | is_b64 | is_ce;
   wire is_prog = (op_q == fesr_pkg::OP_PP) | (op_q == fesr_pkg::OP_PP4) |
      (op_q == fesr_pkg::OP_QPP) | (op_q == fesr_pkg::OP_QPP4) |
      (op_q == fesr_pkg::OP_PSR);
   wire is_wrsr = op_q == fesr_pkg::OP_WRSR;
   wire fmt_ok = bound & (((is_se | is_b32 | is_b64) &
      (bytes_q == abytes + 4'h1)) | (is_ce & (bytes_q == 4'h1)) |
      ((is_prog | is_wrsr) & (bytes_q >= abytes + 4'h2)));
   assign new_kind = is_se ? fesr_pkg::K_SE : is_b32 ? fesr_pkg::K_BE32 :
      is_b64 ? fesr_pkg::K_BE64 : is_ce ? fesr_pkg::K_CE :
      is_prog ? fesr_pkg::K_PP : fesr_pkg::K_WRSR;
   wire busy_w = st_q != S_IDLE;
   wire any_prot = ((prot_q[3:0] != 4'h0) & ~prot_q[5]) |
      (prot_q[5] & (prot_q[3:0] < fesr_pkg::BP_ALL)) | (lock_q != 32'h0);
   wire prot_hit = is_ce ? any_prot :
      blk_prot(cap_addr_q[24:16], prot_q, lock_q);
   wire sv_erase = sv_kind_q != fesr_pkg::K_PP;
   wire same_blk = (is_erase | is_prog) & (is_ce |
      (cap_addr_q[31:16] == sv_addr_q[31:16]));
   wire susp_rej = sus_q & (is_wrsr | same_blk | (sv_erase ?
      (is_erase | (op_q == fesr_pkg::OP_ESR)) : is_prog));
   wire start = cs_rise & fmt_ok & (is_erase | is_prog | is_wrsr) & ~busy_w &
      wl_q & ~susp_rej & ~((is_erase | is_prog) & prot_hit);
   wire suspendable = (kind_q == fesr_pkg::K_SE) |
      (kind_q == fesr_pkg::K_BE32) | (kind_q == fesr_pkg::K_BE64) |
      (kind_q == fesr_pkg::K_PP);
   wire susp_acc = cs_rise & len1 & (op_q == fesr_pkg::OP_SUSP) &
      (st_q == S_RUN) & suspendable & ~sus_q;
   wire res_acc = cs_rise & len1 & (op_q == fesr_pkg::OP_RESM) & sus_q &
      ~busy_w;
   wire done = (st_q == S_RUN) & (cnt_q == 32'h1) & ~susp_acc;
   wire [31:0] kind_mask = (new_kind == fesr_pkg::K_SE) ? fesr_pkg::MASK_4K :
      (new_kind == fesr_pkg::K_BE32) ? fesr_pkg::MASK_32K :
      (new_kind == fesr_pkg::K_BE64) ? fesr_pkg::MASK_64K :
      (new_kind == fesr_pkg::K_CE) ? 32'h0 : fesr_pkg::MASK_PAGE;

   // Operation engine
   logic erase_stb_q, prog_stb_q;
   logic [31:0] arr_addr_q;
   logic [2:0] arr_kind_q;
   wire axi_wr;
   wire [7:0] wr_addr;
   wire [31:0] wr_data;
   always_ff @(posedge CLK_IN or posedge RST_IN)
      if (RST_IN)
      begin
         st_q <= S_IDLE;
         sus_q <= 1'b0;
         wl_q <= 1'b0;
         cnt_q <= 32'h0;
         kind_q <= fesr_pkg::K_WRSR;
         cur_addr_q <= 32'h0;
         sv_cnt_q <= 32'h0;
         sv_kind_q <= fesr_pkg::K_SE;
         sv_addr_q <= 32'h0;
         wrsr_val_q <= 8'h00;
         erase_stb_q <= 1'b0;
         prog_stb_q <= 1'b0;
         arr_addr_q <= 32'h0;
         arr_kind_q <= 3'h0;
         prot_q <= fesr_pkg::PROT_RESET;
      end
      else if (CE_IN)
      begin
         erase_stb_q <= 1'b0;
         prog_stb_q <= 1'b0;
         if (axi_wr && wr_addr == fesr_pkg::REG_PROT)
            prot_q <= wr_data[fesr_pkg::PROT_W-1:0];
         unique case (st_q)
            S_IDLE:
               if (res_acc)
               begin
                  sus_q <= 1'b0;
                  st_q <= S_RUN;
                  cnt_q <= sv_cnt_q;
                  kind_q <= sv_kind_q;
                  cur_addr_q <= sv_addr_q;
               end
               else if (start)
               begin
                  st_q <= S_RUN;
                  cnt_q <= kind_cyc(new_kind);
                  kind_q <= new_kind;
                  cur_addr_q <= cap_addr_q & kind_mask;
                  wrsr_val_q <= dat_q;
               end
            S_RUN:
               if (susp_acc)
               begin
                  sus_q <= 1'b1;
                  st_q <= S_SUSP;
                  sv_cnt_q <= 32'(SUS_LAT_CYC);
               end
               else if (done)
               begin
                  st_q <= S_IDLE;
                  erase_stb_q <= kind_q != fesr_pkg::K_PP &&
                     kind_q != fesr_pkg::K_WRSR;
                  prog_stb_q <= kind_q == fesr_pkg::K_PP;
                  arr_addr_q <= cur_addr_q;
                  arr_kind_q <= kind_q;
                  if (kind_q == fesr_pkg::K_WRSR)
                     prot_q <= wrsr_val_q[fesr_pkg::PROT_W-1:0];
               end
               else
                  cnt_q <= cnt_q - 32'h1;
            S_SUSP:
               if (sv_cnt_q == 32'h1)
               begin
                  st_q <= S_IDLE;
                  sv_cnt_q <= cnt_q;
                  sv_kind_q <= kind_q;
                  sv_addr_q <= cur_addr_q;
               end
               else
                  sv_cnt_q <= sv_cnt_q - 32'h1;
         endcase
         if (done)
            wl_q <= 1'b0;
         else if (cs_rise && len1 && op_q == fesr_pkg::OP_WRDI)
            wl_q <= 1'b0;
         else if (cs_rise && len1 && op_q == fesr_pkg::OP_WREN && !busy_w)
            wl_q <= 1'b1;
      end

   // AXI4-Lite slave; write address and data taken in either order
   logic aw_q, w_q, bvalid_q, rvalid_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [1:0] bresp_q, rresp_q;
   // Frozen core takes nothing, so ready must drop with the enable
   assign S_AXI_AWREADY_OUT = CE_IN & ~aw_q & ~bvalid_q;
   assign S_AXI_WREADY_OUT = CE_IN & ~w_q & ~bvalid_q;
   assign S_AXI_ARREADY_OUT = CE_IN & ~rvalid_q;
   assign axi_wr = aw_q & w_q & ~bvalid_q;
   assign wr_addr = awaddr_q;
   assign wr_data = wdata_q;
   wire wr_ok = (wr_addr == fesr_pkg::REG_CTRL) |
      (wr_addr == fesr_pkg::REG_PROT) | (wr_addr == fesr_pkg::REG_LOCK) |
      (wr_addr == fesr_pkg::REG_STATUS);
   wire [31:0] status_w = {28'h0, sv_erase & sus_q, sus_q, wl_q, busy_w};
   wire [7:0] ra = S_AXI_ARADDR_IN;
   wire rd_ok = (ra == fesr_pkg::REG_CTRL) | (ra == fesr_pkg::REG_PROT) |
      (ra == fesr_pkg::REG_LOCK) | (ra == fesr_pkg::REG_STATUS);
   wire [31:0] rd_mux = (ra == fesr_pkg::REG_CTRL) ? {31'h0, addr4_q} :
      (ra == fesr_pkg::REG_PROT) ? {26'h0, prot_q} :
      (ra == fesr_pkg::REG_LOCK) ? lock_q :
      (ra == fesr_pkg::REG_STATUS) ? status_w : 32'h0;
   always_ff @(posedge CLK_IN or posedge RST_IN)
      if (RST_IN)
      begin
         {aw_q, w_q, bvalid_q, rvalid_q} <= 4'h0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0;
         rdata_q <= 32'h0;
         bresp_q <= fesr_pkg::RESP_OKAY;
         rresp_q <= fesr_pkg::RESP_OKAY;
         addr4_q <= 1'b0;
         lock_q <= fesr_pkg::LOCK_RESET;
      end
      else if (CE_IN)
      begin
         if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)
         begin
            aw_q <= 1'b1;
            awaddr_q <= {S_AXI_AWADDR_IN[7:2], 2'h0};
         end
         if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
         begin
            w_q <= 1'b1;
            wdata_q <= S_AXI_WDATA_IN & {{8{S_AXI_WSTRB_IN[3]}},
               {8{S_AXI_WSTRB_IN[2]}}, {8{S_AXI_WSTRB_IN[1]}},
               {8{S_AXI_WSTRB_IN[0]}}};
         end
         if (axi_wr)
         begin
            {aw_q, w_q, bvalid_q} <= 3'h1;
            bresp_q <= wr_ok ? fesr_pkg::RESP_OKAY : fesr_pkg::RESP_SLVERR;
            // Narrow strobes write zeros in unstrobed lanes
            if (wr_addr == fesr_pkg::REG_CTRL)
               addr4_q <= wr_data[fesr_pkg::CTRL_ADDR4];
            if (wr_addr == fesr_pkg::REG_LOCK)
               lock_q <= wr_data;
         end
         else if (bvalid_q && S_AXI_BREADY_IN)
            bvalid_q <= 1'b0;
         if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT)
         begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_ok ? fesr_pkg::RESP_OKAY : fesr_pkg::RESP_SLVERR;
         end
         else if (rvalid_q && S_AXI_RREADY_IN)
            rvalid_q <= 1'b0;
      end
   assign S_AXI_BVALID_OUT = bvalid_q;
   assign S_AXI_BRESP_OUT = bresp_q;
   assign S_AXI_RVALID_OUT = rvalid_q;
   assign S_AXI_RDATA_OUT = rdata_q;
   assign S_AXI_RRESP_OUT = rresp_q;
   assign ERASE_STB_OUT = erase_stb_q;
   assign PROG_STB_OUT = prog_stb_q;
   assign ARRAY_ADDR_OUT = arr_addr_q;
   assign ARRAY_KIND_OUT = arr_kind_q;
   assign BUSY_OUT = busy_w;
   assign SUSPEND_OUT = sus_q;

   // Checks
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);
   a_wel_needed: assert property (CE_IN && st_q == S_IDLE && !wl_q &&
      !res_acc |=> st_q == S_IDLE)
      else $error("op started without write latch");
   a_wel_cleared: assert property (CE_IN && done |=> !wl_q)
      else $error("write latch not cleared on completion");
   a_bound_drop: assert property (CE_IN && cs_rise && !bound && !busy_w
      |=> !busy_w)
      else $error("partial byte command executed");
   a_prot_block: assert property (CE_IN && cs_rise && is_erase && prot_hit
      && !busy_w |=> !busy_w)
      else $error("protected erase executed");
   a_susp_flag: assert property (CE_IN && susp_acc |=> sus_q && busy_w
      ##[0:SUS_CHK] !busy_w)
      else $error("suspend flag or busy drop wrong");
   a_ce_nosusp: assert property (CE_IN && cs_rise && st_q == S_RUN &&
      kind_q == fesr_pkg::K_CE |=> !sus_q)
      else $error("chip erase was suspended");
   a_res_ignore: assert property (CE_IN && cs_rise && op_q ==
      fesr_pkg::OP_RESM && busy_w |=> sus_q == $past(sus_q))
      else $error("resume taken while busy");
   a_res_busy: assert property (CE_IN && res_acc |=> !sus_q && busy_w)
      else $error("resume did not restart job");
   a_esus_rej: assert property (CE_IN && sus_q && sv_erase && !busy_w &&
      cs_rise && is_erase |=> !busy_w)
      else $error("erase accepted during erase suspend");
   a_b64_align: assert property (ERASE_STB_OUT && ARRAY_KIND_OUT ==
      3'(fesr_pkg::K_BE64) |-> ARRAY_ADDR_OUT[15:0] == 16'h0)
      else $error("64 KB erase base misaligned");
   c_suspend: cover property (susp_acc);
   c_resume: cover property (res_acc);
   c_chip_done: cover property (ERASE_STB_OUT &&
      ARRAY_KIND_OUT == 3'(fesr_pkg::K_CE));
endmodule : fesr_ctrl

// ---- verif/fesr_host.sv ----
// SPI host model: select, serial clock and data in, MSB first.
// Assumes frame is entered just after a rising edge of clk_in.
module fesr_host (
   input wire logic clk_in, // Core clock
   output logic sck_out, // Serial clock, idle low
   output logic cs_n_out, // Select, active low
   output logic di_out // Serial data
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      sck_out = 1'b0;
      cs_n_out = 1'b1;
      di_out = 1'b0;
   end
   // Four core cycles a half period gives the 800 ns link clock
   task automatic frame(input logic [63:0] d, input int n);
      cs_n_out <= 1'b0;
      repeat (4) @(posedge clk_in);
      for (int i = 0; i < n; i++)
      begin
         di_out <= d[63-i];
         repeat (4) @(posedge clk_in);
         sck_out <= 1'b1;
         repeat (4) @(posedge clk_in);
         sck_out <= 1'b0;
      end
      repeat (4) @(posedge clk_in);
      cs_n_out <= 1'b1;
      // Released line shows the inverse, not a stale bit
      di_out <= ~di_out;
      repeat (8) @(posedge clk_in);
   endtask : frame
endmodule : fesr_host

// ---- verif/tb_top.sv ----
// Bench for the erase/suspend sequencer: AXI register tasks, SPI host.
// Assumes short time parameters; chip and 64 KB erase kept long.
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin errors++; \
   $display("wrong value at %0t: %s", $time, m); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
   logic [7:0] aw_a = 0, ar_a = 0;
   logic ce = 1;
   logic [3:0] w_s = 4'hf;
   logic [31:0] w_d = 0, d, a = 32'h0112_3456;
   logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, e_stb, p_stb, busy, susp, h;
   logic sck, cs_n, di;
   logic [1:0] b_rs, r_rs, r;
   logic [31:0] r_d, arr_a;
   logic [2:0] kind;
   int errors = 0, check_count = 0, cyc = 0;
   logic [7:0] op_t [8] = '{8'h20, 8'h52, 8'hd8, 8'h21, 8'hdc, 8'h52, 8'hc7,
      8'h60};
   int nb_t [8] = '{3, 3, 3, 4, 4, 4, 0, 0};
   logic [2:0] kd_t [8] = '{3'h0, 3'h1, 3'h2, 3'h0, 3'h2, 3'h1, 3'h3, 3'h3};
   logic [31:0] mk_t [8] = '{fesr_pkg::MASK_4K, fesr_pkg::MASK_32K,
      fesr_pkg::MASK_64K, fesr_pkg::MASK_4K, fesr_pkg::MASK_64K,
      fesr_pkg::MASK_32K, 32'h0, 32'h0};
   initial
   forever #50 clk = ~clk;
   fesr_host host (.clk_in(clk), .sck_out(sck), .cs_n_out(cs_n), .di_out(di));
   fesr_ctrl #(.SE_TIME_US(1), .BE32_TIME_US(1), .BLOCK64_ERASE_TIME_US(40),
      .CE_TIME_US(20), .PP_TIME_US(1), .WRSR_TIME_US(1), .SUS_LAT_US(1)) dut (
      .CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .SCK_IN(sck), .CS_N_IN(cs_n),
      .DI_IN(di), .S_AXI_AWADDR_IN(aw_a), .S_AXI_AWVALID_IN(aw_v),
      .S_AXI_AWREADY_OUT(aw_rdy), .S_AXI_WDATA_IN(w_d), .S_AXI_WSTRB_IN(w_s),
      .S_AXI_WVALID_IN(w_v), .S_AXI_WREADY_OUT(w_rdy), .S_AXI_BRESP_OUT(b_rs),
      .S_AXI_BVALID_OUT(b_v), .S_AXI_BREADY_IN(b_r), .S_AXI_ARADDR_IN(ar_a),
      .S_AXI_ARVALID_IN(ar_v), .S_AXI_ARREADY_OUT(ar_rdy),
      .S_AXI_RDATA_OUT(r_d), .S_AXI_RRESP_OUT(r_rs), .S_AXI_RVALID_OUT(r_v),
      .S_AXI_RREADY_IN(r_r), .ERASE_STB_OUT(e_stb), .PROG_STB_OUT(p_stb),
      .ARRAY_ADDR_OUT(arr_a), .ARRAY_KIND_OUT(kind), .BUSY_OUT(busy),
      .SUSPEND_OUT(susp));
   task automatic end_of_test();
      if (errors == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         errors++;
         end_of_test();
      end
   end
   // Bus tasks: entered just after a rising edge, values taken mid-cycle
   task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
      logic ta, tw, bv;
      aw_a <= ad;
      w_d <= wd;
      aw_v <= 1'b1;
      w_v <= 1'b1;
      b_r <= 1'b1;
      forever
      begin
         @(negedge clk);
         {ta, tw, bv, r} = {aw_v & aw_rdy, w_v & w_rdy, b_v, b_rs};
         @(posedge clk);
         if (ta) aw_v <= 1'b0;
         if (tw) w_v <= 1'b0;
         if (bv) break;
      end
      b_r <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] ad);
      logic ta, rv;
      ar_a <= ad;
      ar_v <= 1'b1;
      r_r <= 1'b1;
      forever
      begin
         @(negedge clk);
         {ta, rv, d, r} = {ar_v & ar_rdy, r_v, r_d, r_rs};
         @(posedge clk);
         if (ta) ar_v <= 1'b0;
         if (rv) break;
      end
      r_r <= 1'b0;
      @(posedge clk);
   endtask : rd
   task automatic sp(input logic [7:0] op, input int nb, input int ex);
      logic [63:0] f = {op, 56'h0};
      if (nb == 3) f[55:32] = a[23:0];
      if (nb == 4) f[55:24] = a;
      host.frame(f, 8 + 8 * nb + ex);
   endtask : sp
   task automatic quiet();
      logic b = 1'b0;
      repeat (40)
      begin
         @(negedge clk);
         b = b | busy;
      end
      @(posedge clk);
      `CHK(b, 1'b0, "refused command ran")
   endtask : quiet
   task automatic wstb();
      h = 1'b0;
      repeat (3000)
      begin
         @(negedge clk);
         if (e_stb === 1'b1 || p_stb === 1'b1)
         begin
            h = 1'b1;
            break;
         end
      end
      @(posedge clk);
      `CHK(h, 1'b1, "no end strobe")
   endtask : wstb
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      rd(fesr_pkg::REG_STATUS);
      `CHK(d, 32'h0, "status after reset")
      rd(8'h10);
      `CHK(r, fesr_pkg::RESP_SLVERR, "unmapped read")
      wr(8'h10, 32'h1);
      `CHK(r, fesr_pkg::RESP_SLVERR, "unmapped write")
      sp(8'h20, 3, 0);
      quiet();
      sp(8'h06, 0, 0);
      sp(8'h20, 3, -1);
      quiet();
      w_s <= 4'h4;
      wr(fesr_pkg::REG_LOCK, 32'hfffc_0000);
      w_s <= 4'hf;
      rd(fesr_pkg::REG_LOCK);
      `CHK(d, 32'h00fc_0000, "narrow lock write")
      sp(8'h20, 3, 0);
      quiet();
      wr(fesr_pkg::REG_LOCK, 32'h0);
      wr(fesr_pkg::REG_PROT, 32'h1);
      sp(8'hc7, 0, 0);
      quiet();
      wr(fesr_pkg::REG_PROT, 32'h0);
      for (int i = 0; i < 8; i++)
      begin
         if (i == 5) wr(fesr_pkg::REG_CTRL, 32'h1);
         sp(8'h06, 0, 0);
         sp(op_t[i], nb_t[i], 0);
         if (kd_t[i] > 3'h1) rd(fesr_pkg::REG_STATUS);
         if (kd_t[i] > 3'h1) `CHK(d[0], 1'b1, "busy in erase")
         wstb();
         `CHK(arr_a, (nb_t[i] == 4 ? a : {8'h0, a[23:0]}) & mk_t[i], "addr")
         `CHK(kind, kd_t[i], "erase kind")
         rd(fesr_pkg::REG_STATUS);
         `CHK(d[1:0], 2'h0, "latch or busy left")
         if (i == 5) wr(fesr_pkg::REG_CTRL, 32'h0);
      end
      sp(8'h06, 0, 0);
      sp(8'h20, 3, 0);
      ce <= 1'b0;
      repeat (30) @(posedge clk);
      `CHK(busy, 1'b1, "clock enable freeze")
      ce <= 1'b1;
      wstb();
      `CHK(kind, 3'h0, "erase after freeze")
      sp(8'h06, 0, 0);
      sp(8'hd8, 3, 0);
      sp(8'h75, 0, 0);
      `CHK(susp, 1'b1, "suspend flag")
      repeat (20) @(posedge clk);
      rd(fesr_pkg::REG_STATUS);
      `CHK(d[3:0], 4'he, "suspended erase state")
      a = 32'h0000_0100;
      sp(8'h06, 0, 0);
      sp(8'h20, 3, 0);
      quiet();
      sp(8'h02, 3, 8);
      wstb();
      `CHK({kind, arr_a}, {3'h4, a}, "program elsewhere")
      sp(8'h7a, 0, 0);
      `CHK({susp, busy}, 2'b01, "resume")
      wstb();
      `CHK({kind, arr_a}, {3'h2, 32'h0012_0000}, "resumed erase")
      sp(8'h06, 0, 0);
      sp(8'hc7, 0, 0);
      sp(8'h75, 0, 0);
      `CHK(susp, 1'b0, "suspend in chip erase")
      wstb();
      sp(8'h7a, 0, 0);
      quiet();
      sp(8'h06, 0, 0);
      sp(8'hd8, 3, 0);
      sp(8'h75, 0, 0);
      repeat (20) @(posedge clk);
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      `CHK({susp, busy}, 2'b00, "flag after power loss")
      sp(8'h7a, 0, 0);
      quiet();
      end_of_test();
   end
endmodule : tb_top
